// File: hdl/flash_bus_cycle.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_defs.svh"

// One flash bus cycle: holds active_o high for a set length, then a hold gap
module flash_bus_cycle
    import flash_status_pkg::*;
#(
    parameter int ACTIVE_CYCLES = `READ_CYCLES,
    parameter int GAP_CYCLES = `HOLD_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset
    input wire logic go_i, // Start one cycle
    output logic active_o, // Strobe phase
    output logic done_o // Pulse at end of gap
);
    initial begin
        if (ACTIVE_CYCLES < 1 || ACTIVE_CYCLES > 15 || GAP_CYCLES < 1 || GAP_CYCLES > 15) begin
            $error("flash_bus_cycle: counts out of range");
        end
    end

    typedef struct packed {
        logic active; // Strobe phase
        logic gap; // Hold phase
        logic done; // End pulse
        logic [`CNT_W-1:0] cnt; // Phase counter
    } cyc_t;

    cyc_t r;
    cyc_t next_r;

    // Phase sequencing
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (r.active) begin
            if (r.cnt == `CNT_W'(ACTIVE_CYCLES - 1)) begin
                next_r.active = 1'b0;
                next_r.gap = 1'b1;
                next_r.cnt = '0;
            end else begin
                next_r.cnt = r.cnt + `CNT_W'(1);
            end
        end else if (r.gap) begin
            if (r.cnt == `CNT_W'(GAP_CYCLES - 1)) begin
                next_r.gap = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.cnt = r.cnt + `CNT_W'(1);
            end
        end else if (go_i) begin
            next_r.active = 1'b1;
            next_r.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign active_o = r.active;
    assign done_o = r.done;
endmodule
`default_nettype wire

// File: hdl/flash_status_defs.svh
`ifndef FLASH_STATUS_DEFS_SVH
`define FLASH_STATUS_DEFS_SVH

// Command register map (byte addresses of software port)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_ERASE_ADDR 4'h8
`define REG_CYCLES 4'hc
// Control register fields
`define CTRL_START_BIT 0
`define CTRL_CHECK_BIT 1
`define CTRL_ABORT_BIT 2
// Status register fields
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_FAIL_BIT 2
`define ST_WINDOW_BIT 3
`define ST_READY_BIT 4
`define ST_SECTOR_TOG_BIT 5
// Flash data bit positions of the status bits
`define FL_POLL_BIT 7
`define FL_TOGGLE_BIT 6
`define FL_TIMEOUT_BIT 5
`define FL_WINDOW_BIT 3
`define FL_SECTOR_BIT 2
// Reset command written to the flash
`define FLASH_RESET_DATA 8'hf0
`define FLASH_RESET_ADDR 20'h00000
// Bus timing on the flash side, in ns
`define READ_CYCLE_NS 55
`define OE_HOLD_NS 10
`define WRITE_PULSE_NS 35
// Cycle counts rounded up at 8 ns
`define CLK_NS 8
`define READ_CYCLES ((`READ_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYCLES ((`OE_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define WRITE_CYCLES ((`WRITE_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 4

`endif

// File: hdl/flash_status_pkg.sv
package flash_status_pkg;
    // Sequencer states of the status poller
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_READ,
        ST_GAP,
        ST_EVAL,
        ST_WRITE,
        ST_WGAP
    } poll_state_t;
    // Which step of the toggle procedure a read serves
    typedef enum logic [1:0] {
        STEP_FIRST,
        STEP_SECOND,
        STEP_RECHECK
    } poll_step_t;
endpackage

// File: hdl/flash_status_poller.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_defs.svh"

// Function
// - Host reads twice, equal means done
// - Toggling with timeout set: recheck, reset
// - Resumed monitoring restarts full procedure
// - Host resets flash after timeout failure
// - Skip window check only under 50 us; the poller never skips it, window bit is taken on every read
// - Check window before and after extra erase
module flash_status_poller
    import flash_status_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 8
) (
    input wire logic clk_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset
    input wire logic [3:0] addr_i, // Register address
    input wire logic [31:0] wdata_i, // Register write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [31:0] rdata_o, // Read data, one cycle later
    output logic [ADDR_W-1:0] flash_addr_o, // Flash address
    input wire logic [DATA_W-1:0] flash_dq_i, // Flash data in
    output logic [DATA_W-1:0] flash_dq_o, // Flash data out
    output logic flash_dq_oe_o, // Data drive enable
    output logic flash_ce_n_o, // Chip enable
    output logic flash_oe_n_o, // Output enable
    output logic flash_we_n_o, // Write enable
    input wire logic ready_busy_n_i, // Shared busy line level
    output logic busy_o, // Poll or reset write in progress
    output logic done_o, // Operation ended well
    output logic fail_o // Operation failed
);
    initial begin
        if (ADDR_W < 20 || ADDR_W > 32 || DATA_W < 8) begin
            $error("flash_status_poller: bus width out of range");
        end
    end

    typedef struct packed {
        poll_state_t st; // Sequencer state
        poll_step_t step; // Procedure step
        logic first_tog; // Toggle value of earlier read
        logic busy; // Poll or reset write running
        logic done; // Completed
        logic fail; // Failed
        logic window; // Erase window bit seen
        logic sector_tog; // Sector toggle seen
        logic ready; // Busy line level seen
        logic [ADDR_W-1:0] addr; // Flash address
        logic [DATA_W-1:0] dq; // Flash data out
        logic dq_oe; // Data drive
        logic ce_n; // Chip enable
        logic oe_n; // Output enable
        logic we_n; // Write enable
        logic [DATA_W-1:0] last; // Last status byte
        logic [15:0] reads; // Reads performed
        logic [31:0] rdata; // Register read data
        logic go_rd; // Start read cycle
        logic go_wr; // Start write cycle
    } state_t;

    state_t r;
    state_t next_r;
    logic rd_active;
    logic rd_done;
    logic wr_active;
    logic wr_done;

    // Read cycle timer: strobe held one full access, then hold gap
    flash_bus_cycle #(
        .ACTIVE_CYCLES(`READ_CYCLES),
        .GAP_CYCLES(`HOLD_CYCLES)
    ) u_read (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .go_i(r.go_rd),
        .active_o(rd_active),
        .done_o(rd_done)
    );

    // Write cycle timer for the reset command
    flash_bus_cycle #(
        .ACTIVE_CYCLES(`WRITE_CYCLES),
        .GAP_CYCLES(`HOLD_CYCLES)
    ) u_write (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .go_i(r.go_wr),
        .active_o(wr_active),
        .done_o(wr_done)
    );

    // Sequencer and register port
    always_comb begin
        next_r = r;
        next_r.go_rd = 1'b0;
        next_r.go_wr = 1'b0;
        next_r.ready = ready_busy_n_i;
        // Register reads
        next_r.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                `REG_STATUS: begin
                    next_r.rdata[`ST_BUSY_BIT] = r.busy;
                    next_r.rdata[`ST_DONE_BIT] = r.done;
                    next_r.rdata[`ST_FAIL_BIT] = r.fail;
                    next_r.rdata[`ST_WINDOW_BIT] = r.window;
                    next_r.rdata[`ST_READY_BIT] = r.ready;
                    next_r.rdata[`ST_SECTOR_TOG_BIT] = r.sector_tog;
                end
                `REG_ERASE_ADDR: next_r.rdata[ADDR_W-1:0] = r.addr;
                `REG_CYCLES: next_r.rdata[15:0] = r.reads;
                default: next_r.rdata = '0;
            endcase
        end
        // Register writes
        if (wr_i && addr_i == `REG_ERASE_ADDR && !r.busy) begin
            next_r.addr = wdata_i[ADDR_W-1:0];
        end
        case (r.st)
            ST_IDLE: begin
                if (wr_i && addr_i == `REG_CTRL) begin
                    if (wdata_i[`CTRL_ABORT_BIT]) begin
                        next_r.st = ST_WRITE;
                        next_r.addr = ADDR_W'(`FLASH_RESET_ADDR);
                        next_r.go_wr = 1'b1;
                        next_r.busy = 1'b1;
                    end else if (wdata_i[`CTRL_START_BIT] || wdata_i[`CTRL_CHECK_BIT]) begin
                        // Each start begins from the first read
                        next_r.step = STEP_FIRST;
                        next_r.busy = 1'b1;
                        next_r.done = 1'b0;
                        next_r.fail = 1'b0;
                        next_r.reads = '0;
                        next_r.go_rd = 1'b1;
                        next_r.st = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // Sample while strobes stay low, before release
                if (rd_active) begin
                    next_r.last = flash_dq_i;
                end else if (rd_done) begin
                    next_r.st = ST_EVAL;
                    next_r.reads = r.reads + 16'h0001;
                end
            end
            ST_EVAL: begin
                // Window bit taken on every read, never skipped
                next_r.window = r.last[`FL_WINDOW_BIT];
                next_r.sector_tog = r.last[`FL_SECTOR_BIT];
                case (r.step)
                    STEP_FIRST: begin
                        next_r.first_tog = r.last[`FL_TOGGLE_BIT];
                        next_r.step = STEP_SECOND;
                        next_r.go_rd = 1'b1;
                        next_r.st = ST_READ;
                    end
                    default: begin
                        if (r.last[`FL_TOGGLE_BIT] == r.first_tog) begin
                            // Stable toggle bit: finished
                            next_r.done = 1'b1;
                            next_r.busy = 1'b0;
                            next_r.st = ST_IDLE;
                        end else if (r.step == STEP_RECHECK) begin
                            // Still toggling after timeout: reset flash
                            next_r.fail = 1'b1;
                            next_r.addr = ADDR_W'(`FLASH_RESET_ADDR);
                            next_r.go_wr = 1'b1;
                            next_r.st = ST_WRITE;
                        end else begin
                            if (r.last[`FL_TIMEOUT_BIT]) begin
                                next_r.step = STEP_RECHECK;
                            end
                            // Keep polling; covers 2 us and 100 us cases
                            next_r.first_tog = r.last[`FL_TOGGLE_BIT];
                            next_r.go_rd = 1'b1;
                            next_r.st = ST_READ;
                        end
                    end
                endcase
            end
            ST_WRITE: begin
                next_r.dq = DATA_W'(`FLASH_RESET_DATA);
                next_r.dq_oe = 1'b1;
                if (wr_done) begin
                    next_r.dq_oe = 1'b0;
                    next_r.busy = 1'b0;
                    next_r.st = ST_IDLE;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
        // Pin strobes follow the timer phase only, one cycle behind it,
        // so the start cycle never leaves a stray one-cycle strobe pulse
        next_r.ce_n = !(rd_active || wr_active);
        next_r.oe_n = !rd_active;
        next_r.we_n = !wr_active;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.step <= STEP_FIRST;
            r.ce_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.we_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_o = r.rdata;
    assign flash_addr_o = r.addr;
    assign flash_dq_o = r.dq;
    assign flash_dq_oe_o = r.dq_oe;
    assign flash_ce_n_o = r.ce_n;
    assign flash_oe_n_o = r.oe_n;
    assign flash_we_n_o = r.we_n;
    assign busy_o = r.busy;
    assign done_o = r.done;
    assign fail_o = r.fail;
endmodule
`default_nettype wire

// File: test/flash_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// Flash status behaviour during an embedded operation
module flash_dev_model (
    input wire logic clk_i, // Clock
    input wire logic ce_n_i, // Chip enable
    input wire logic oe_n_i, // Output enable
    input wire logic we_n_i, // Write enable
    input wire logic [7:0] wd_i, // Written data
    input wire logic go_i, // Command sequence ends
    input wire logic [7:0] reads_i, // Reads until done
    input wire logic tmo_i, // Operation overruns
    input wire logic erase_i, // Operation is an erase
    output logic [7:0] dq_o, // Data to controller
    output logic rb_low_o // Pulls busy line low
);
    logic busy = 0, tog = 0, stog = 0, tmo = 0, er = 0, rd_q = 0, wr_q = 0; // State
    logic [7:0] left = 0, seen = 0, st, last = 0; // Counts and status
    wire rd = !ce_n_i && !oe_n_i; // Read cycle
    wire wr = !ce_n_i && !we_n_i; // Write cycle
    // Status byte; polling, fail and window bits
    assign st = {~(busy & er), tog, tmo, 1'b0, er && seen >= 2, stog, 2'b00};
    assign dq_o = rd ? st : ~last;
    assign rb_low_o = busy;
    // Status advances at the end of each read
    always @(posedge clk_i) begin
        rd_q <= rd;
        wr_q <= wr;
        if (rd) last <= st;
        if (go_i) begin
            busy <= 1'b1;
            left <= reads_i;
            tmo <= tmo_i;
            er <= erase_i;
            seen <= 8'h0;
        end else if (rd_q && !rd) begin
            seen <= seen + 8'h1;
            if (busy) begin
                tog <= ~tog;
                stog <= stog ^ er;
                if (!tmo) begin
                    left <= left - 8'h1;
                    if (left <= 8'h1) busy <= 1'b0;
                end
            end
        end else if (wr_q && !wr && wd_i == 8'hf0) begin
            busy <= 1'b0;
            tmo <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: test/flash_status_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the poller's ports for bus and sequence hazards
module flash_status_chk #(
    parameter int DATA_W = 8
) (
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic [3:0] addr_i, // Address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [31:0] rdata_o, // Read data
    input wire logic [DATA_W-1:0] flash_dq_o, // Flash data out
    input wire logic flash_dq_oe_o, // Data drive
    input wire logic flash_ce_n_o, // Chip enable
    input wire logic flash_oe_n_o, // Output enable
    input wire logic flash_we_n_o, // Write enable
    input wire logic busy_o, // Busy
    input wire logic done_o, // Done
    input wire logic fail_o // Fail
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Strobe phase and hold gap of one flash read
    sequence rd_pulse;
        !flash_oe_n_o [*7];
    endsequence
    sequence rd_gap;
        flash_oe_n_o [*2];
    endsequence
    rd_pulse_len_a: assert property ($fell(flash_oe_n_o) |-> rd_pulse)
        else $error("read strobe too short");
    rd_gap_len_a: assert property ($rose(flash_oe_n_o) |-> rd_gap)
        else $error("read gap too short");
    strobe_clash_a: assert property (!(!flash_oe_n_o && !flash_we_n_o))
        else $error("read and write strobes together");
    ce_with_oe_a: assert property (!flash_oe_n_o |-> !flash_ce_n_o)
        else $error("output enable without chip enable");
    wr_pulse_len_a: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*5])
        else $error("write pulse too short");
    reset_cmd_a: assert property (!flash_we_n_o |-> flash_dq_oe_o && flash_dq_o == 8'hf0)
        else $error("write is not the reset command");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    start_reads_a: assert property ((wr_i && addr_i == 4'h0 && wdata_i[0] && !busy_o)
        |-> ##[1:3] !flash_oe_n_o)
        else $error("start gave no read");
    end_excl_a: assert property (!(done_o && fail_o))
        else $error("done and fail together");
endmodule
bind flash_status_poller flash_status_chk #(.DATA_W(DATA_W)) chk_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
    .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
    .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o));
`default_nettype wire

// File: test/flash_write_status_reporting_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module flash_write_status_reporting_tb_top;
    logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, go = 0, tmo = 0, er = 0; // Drives
    logic [3:0] addr_i = 0; // Address
    logic [31:0] wdata_i = 0, rdata_o, rv, seed = 32'h3e695bde; // Bus and seed
    logic [19:0] fa; // Flash address
    logic [7:0] dq_o, dq_i, n = 0; // Flash data
    logic oe, ce, oe_n, we_n, rb_low, busy_o, done_o, fail_o; // Pins and flags
    int num_errors = 0, cmp_count = 0, cyc = 0, t; // Counters
    always #4 clk_i = ~clk_i; // 125 MHz
    flash_status_poller dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flash_addr_o(fa),
        .flash_dq_i(dq_i), .flash_dq_o(dq_o), .flash_dq_oe_o(oe), .flash_ce_n_o(ce),
        .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .ready_busy_n_i(~rb_low), .busy_o(busy_o),
        .done_o(done_o), .fail_o(fail_o));
    flash_dev_model dev (.clk_i(clk_i), .ce_n_i(ce), .oe_n_i(oe_n), .we_n_i(we_n),
        .wd_i(dq_o), .go_i(go), .reads_i(n), .tmo_i(tmo), .erase_i(er), .dq_o(dq_i),
        .rb_low_o(rb_low));
    // Hang guard
    always @(posedge clk_i) if (++cyc == 40000) begin
        num_errors++;
        wrap_up();
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1;
        @(posedge clk_i);
        wr_i <= 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1;
        @(posedge clk_i);
        rd_i <= 0;
        #1 rv = rdata_o;
    endtask
    // Wait for the poller to go idle; a limit that runs out is a mismatch
    task automatic wait_idle();
        #1;
        t = 0;
        while (busy_o !== 1'b0 && t < 3000) begin
            @(posedge clk_i);
            #1;
            t++;
        end
        chk("idle", 32'h0, {31'h0, busy_o});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One operation: model start, poll, then compare outcome
    task automatic run_op(input logic [7:0] k, input logic f, input logic e);
        @(posedge clk_i);
        n <= k;
        tmo <= f;
        er <= e;
        go <= 1;
        @(posedge clk_i);
        go <= 0;
        wr(4'h0, {30'h0, e, !e});
        rd(4'h4);
        chk("busy bit", 32'h1, rv & 32'h11);
        wr(4'h0, 32'h2); // Refused while busy
        wait_idle();
        repeat (4) @(posedge clk_i);
        chk("done", {31'h0, !f}, {31'h0, done_o});
        chk("fail", {31'h0, f}, {31'h0, fail_o});
        rd(4'hc);
        chk("reads", f ? 32'h3 : 32'(k) + 32'h2, rv);
        rd(4'h4);
        chk("status", {27'h0, 1'b1, e, f, !f, 1'b0}, rv & 32'h1f);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 0;
        run_op(8'h1, 0, 0);
        run_op(8'h1, 1, 1);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            run_op({4'h0, seed[3:0] | 4'h1}, seed[4] & seed[5], seed[6]);
        end
        seed = xs(seed);
        wr(4'h8, {12'h0, seed[19:0]});
        rd(4'h8);
        chk("erase addr", {12'h0, seed[19:0]}, rv);
        chk("flash addr", {12'h0, seed[19:0]}, {12'h0, fa});
        wr(4'h0, 32'h4);
        wait_idle();
        rd(4'h8);
        chk("reset addr", 32'h0, rv);
        chk("reset flash addr", 32'h0, {12'h0, fa});
        rd(4'h2);
        chk("unmapped", 32'h0, rv);
        wrap_up();
    end
endmodule
`default_nettype wire
